// *** include/rlnr_pkg.sv ***
// constants for the nmi-return / rotate-left-through-carry execution block
// assumes an 8-bit data path, 16-bit addresses and a byte-wide flag register
package rlnr_pkg;
    // instruction bytes
    localparam logic [7:0] BIT_PFX = 8'hCB;     // bit-operation prefix
    localparam logic [7:0] IDX_PFX_A = 8'hDD;   // index prefix, first_index_reg
    localparam logic [7:0] IDX_PFX_B = 8'hFD;   // index prefix, second_index_reg
    localparam logic [7:0] EXT_PFX = 8'hED;     // extended prefix
    localparam logic [7:0] NMI_RET_OP = 8'h45;  // nmi_return_op second byte
    localparam logic [4:0] ROT_GRP = 5'h02;     // upper fields 00 010
    localparam logic [2:0] MEM_FIELD = 3'h6;    // operand field 110 = memory
    // stack handling
    localparam logic [15:0] SP_STEP = 16'h0002; // stack grows back by one word
    localparam int MSW_LOW_W = 8;               // master_status_word bits 0-7
    // flag positions
    localparam int FLG_C = 0;
    localparam int FLG_N = 1;
    localparam int FLG_PV = 2;
    localparam int FLG_H = 4;
    localparam int FLG_Z = 6;
    localparam int FLG_S = 7;
    // reset values
    localparam logic [7:0] FLAGS_RST = 8'h00;
    localparam logic [15:0] WORD_RST = 16'h0000;
    // decoder / sequencer states, one-hot
    typedef enum logic [9:0] {
        ST_IDLE = 10'h001,
        ST_EXT = 10'h002,
        ST_BIT = 10'h004,
        ST_IDX = 10'h008,
        ST_IDX_BIT = 10'h010,
        ST_IDX_OP = 10'h020,
        ST_REG_RD = 10'h040,
        ST_MEM_RD = 10'h080,
        ST_MEM_WR = 10'h100,
        ST_STACK = 10'h200
    } rlnr_state_t;
endpackage : rlnr_pkg

// *** hw/rlnr_rotate.sv ***
// combinational rotate-left-through-carry with its flag results
// assumes the caller registers the outputs
`timescale 1ns/1ns
module rlnr_rotate (
    input wire logic [7:0] operand,
    input wire logic [7:0] flags_old,
    output logic [7:0] result,
    output logic [7:0] flags_new
);
    // old carry enters bit 0, old bit 7 leaves into carry
    always_comb begin
        result = {operand[6:0], flags_old[rlnr_pkg::FLG_C]};
        flags_new = flags_old; // undocumented bits 3 and 5 left alone
        flags_new[rlnr_pkg::FLG_S] = result[7];
        flags_new[rlnr_pkg::FLG_Z] = (result == 8'h00);
        flags_new[rlnr_pkg::FLG_H] = 1'b0;
        flags_new[rlnr_pkg::FLG_PV] = ~^result;
        flags_new[rlnr_pkg::FLG_N] = 1'b0;
        flags_new[rlnr_pkg::FLG_C] = operand[7];
    end
endmodule : rlnr_rotate

// *** hw/rlnr_core.sv ***
// Overview of operation
// - nmi return pops pc, sp plus two
// - nmi return restores master status bits 0-7
// - rotate left, carry into bit 0
// - zero flag from result; half, subtract cleared
// - parity flag set on even one count
// - carry takes the old bit 7
// - bit prefix plus 00 010 r; 110 is memory
// - index prefix, bit prefix, displacement, opcode
//
// execution slice: byte decoder plus sequencer for the two instructions
// assumes register file answers reg_rd_data in the same cycle that reg_sel_q takes its new value,
// and memory holds mem_rdata valid with mem_ack
`timescale 1ns/1ns
module rlnr_core #(
    parameter int ADDR_W = 16
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic ins_valid,
    input wire logic [7:0] ins_byte,
    output logic ins_ready_q,
    input wire logic [7:0] flags_in,
    input wire logic [7:0] reg_rd_data,
    input wire logic [15:0] stack_ptr_in,
    input wire logic [15:0] pointer_pair,
    input wire logic [15:0] first_index_reg,
    input wire logic [15:0] second_index_reg,
    input wire logic [7:0] saved_interrupt_mask_copy,
    input wire logic mem_ack,
    input wire logic [15:0] mem_rdata,
    output logic mem_req_q,
    output logic mem_we_q,
    output logic mem_word_q,
    output logic [15:0] mem_addr_q,
    output logic [7:0] mem_wdata_q,
    output logic [2:0] reg_sel_q,
    output logic reg_we_q,
    output logic [7:0] reg_wdata_q,
    output logic flags_we_q,
    output logic [7:0] flags_q,
    output logic pc_load_q,
    output logic [15:0] pc_q,
    output logic sp_load_q,
    output logic [15:0] sp_q,
    output logic msw_load_q,
    output logic [7:0] master_status_word_q
);
    // the slice only knows 16-bit addressing
    if (ADDR_W != 16) begin : g_bad_width
        $error("rlnr_core: ADDR_W must be 16");
    end

    rlnr_pkg::rlnr_state_t state_q; // sequencer state
    logic take; // a byte is accepted this cycle
    logic idx_b_q; // index prefix chose second_index_reg
    logic [7:0] disp_q; // short-index displacement
    logic [7:0] operand; // value fed to the rotator
    logic [7:0] rot_res; // rotator result
    logic [7:0] rot_flags; // rotator flags
    logic [15:0] idx_base; // chosen index register
    logic [15:0] idx_addr; // index plus signed displacement
    logic [7:0] res_q; // last rotate result, also checked

    assign take = clk_en && ins_valid && ins_ready_q;
    assign operand = state_q[6] ? reg_rd_data : mem_rdata[7:0];
    assign idx_base = idx_b_q ? second_index_reg : first_index_reg;
    assign idx_addr = 16'(idx_base + {{8{disp_q[7]}}, disp_q});

    rlnr_rotate u_rot (
        .operand(operand),
        .flags_old(flags_in),
        .result(rot_res),
        .flags_new(rot_flags)
    );

    // decoder and sequencer
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= rlnr_pkg::ST_IDLE;
            idx_b_q <= 1'b0;
            disp_q <= 8'h00;
            reg_sel_q <= 3'h0;
            mem_addr_q <= rlnr_pkg::WORD_RST;
            mem_word_q <= 1'b0;
        end else if (clk_en) begin
            case (state_q)
                rlnr_pkg::ST_IDLE: begin
                    if (take) begin
                        if (ins_byte == rlnr_pkg::BIT_PFX) begin
                            state_q <= rlnr_pkg::ST_BIT;
                        end else if (ins_byte == rlnr_pkg::EXT_PFX) begin
                            state_q <= rlnr_pkg::ST_EXT;
                        end else if (ins_byte == rlnr_pkg::IDX_PFX_A ||
                                     ins_byte == rlnr_pkg::IDX_PFX_B) begin
                            idx_b_q <= ins_byte[5];
                            state_q <= rlnr_pkg::ST_IDX;
                        end
                    end
                end
                rlnr_pkg::ST_EXT: begin
                    if (take) begin
                        // other extended opcodes belong to other slices
                        if (ins_byte == rlnr_pkg::NMI_RET_OP) begin
                            mem_addr_q <= stack_ptr_in;
                            mem_word_q <= 1'b1;
                            state_q <= rlnr_pkg::ST_STACK;
                        end else begin
                            state_q <= rlnr_pkg::ST_IDLE;
                        end
                    end
                end
                rlnr_pkg::ST_BIT: begin
                    if (take) begin
                        mem_word_q <= 1'b0;
                        if (ins_byte[7:3] != rlnr_pkg::ROT_GRP) begin
                            state_q <= rlnr_pkg::ST_IDLE;
                        end else if (ins_byte[2:0] == rlnr_pkg::MEM_FIELD) begin
                            mem_addr_q <= pointer_pair;
                            state_q <= rlnr_pkg::ST_MEM_RD;
                        end else begin
                            reg_sel_q <= ins_byte[2:0];
                            state_q <= rlnr_pkg::ST_REG_RD;
                        end
                    end
                end
                rlnr_pkg::ST_IDX: begin
                    if (take) begin
                        state_q <= (ins_byte == rlnr_pkg::BIT_PFX) ?
                            rlnr_pkg::ST_IDX_BIT : rlnr_pkg::ST_IDLE;
                    end
                end
                rlnr_pkg::ST_IDX_BIT: begin
                    if (take) begin
                        disp_q <= ins_byte;
                        state_q <= rlnr_pkg::ST_IDX_OP;
                    end
                end
                rlnr_pkg::ST_IDX_OP: begin
                    if (take) begin
                        // only the memory field is legal in this form
                        if (ins_byte == {rlnr_pkg::ROT_GRP, rlnr_pkg::MEM_FIELD}) begin
                            mem_addr_q <= idx_addr;
                            mem_word_q <= 1'b0;
                            state_q <= rlnr_pkg::ST_MEM_RD;
                        end else begin
                            state_q <= rlnr_pkg::ST_IDLE;
                        end
                    end
                end
                rlnr_pkg::ST_REG_RD: begin
                    state_q <= rlnr_pkg::ST_IDLE;
                end
                rlnr_pkg::ST_MEM_RD: begin
                    if (mem_ack) begin
                        state_q <= rlnr_pkg::ST_MEM_WR;
                    end
                end
                rlnr_pkg::ST_MEM_WR, rlnr_pkg::ST_STACK: begin
                    if (mem_ack) begin
                        state_q <= rlnr_pkg::ST_IDLE;
                    end
                end
                default: begin
                    state_q <= rlnr_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // byte acceptance and memory strobes follow the next state
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ins_ready_q <= 1'b0;
            mem_req_q <= 1'b0;
            mem_we_q <= 1'b0;
        end else if (clk_en) begin
            ins_ready_q <= 1'b0;
            mem_req_q <= 1'b0;
            mem_we_q <= 1'b0;
            case (state_q)
                rlnr_pkg::ST_IDLE, rlnr_pkg::ST_EXT, rlnr_pkg::ST_BIT,
                rlnr_pkg::ST_IDX, rlnr_pkg::ST_IDX_BIT, rlnr_pkg::ST_IDX_OP: begin
                    // stop taking bytes once an operand access starts
                    ins_ready_q <= !(take && (ins_byte[2:0] == rlnr_pkg::MEM_FIELD
                        || state_q == rlnr_pkg::ST_BIT
                        || ins_byte == rlnr_pkg::NMI_RET_OP)
                        && (state_q == rlnr_pkg::ST_BIT || state_q == rlnr_pkg::ST_EXT
                        || state_q == rlnr_pkg::ST_IDX_OP));
                    mem_req_q <= take && ((state_q == rlnr_pkg::ST_BIT
                        && ins_byte == {rlnr_pkg::ROT_GRP, rlnr_pkg::MEM_FIELD})
                        || (state_q == rlnr_pkg::ST_IDX_OP
                        && ins_byte == {rlnr_pkg::ROT_GRP, rlnr_pkg::MEM_FIELD})
                        || (state_q == rlnr_pkg::ST_EXT
                        && ins_byte == rlnr_pkg::NMI_RET_OP));
                end
                rlnr_pkg::ST_MEM_RD: begin
                    mem_req_q <= 1'b1; // read, then the write-back
                    mem_we_q <= mem_ack;
                end
                rlnr_pkg::ST_MEM_WR, rlnr_pkg::ST_STACK: begin
                    mem_req_q <= !mem_ack;
                    mem_we_q <= !mem_ack && state_q == rlnr_pkg::ST_MEM_WR;
                    ins_ready_q <= mem_ack;
                end
                rlnr_pkg::ST_REG_RD: begin
                    ins_ready_q <= 1'b1;
                end
                default: begin
                    ins_ready_q <= 1'b0;
                end
            endcase
        end
    end

    // rotate results: register write-back, memory write data and flags
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_we_q <= 1'b0;
            reg_wdata_q <= 8'h00;
            mem_wdata_q <= 8'h00;
            flags_we_q <= 1'b0;
            flags_q <= rlnr_pkg::FLAGS_RST;
            res_q <= 8'h00;
        end else if (clk_en) begin
            reg_we_q <= 1'b0;
            flags_we_q <= 1'b0;
            if (state_q == rlnr_pkg::ST_REG_RD ||
                (state_q == rlnr_pkg::ST_MEM_RD && mem_ack)) begin
                reg_we_q <= state_q == rlnr_pkg::ST_REG_RD;
                reg_wdata_q <= rot_res;
                mem_wdata_q <= rot_res;
                res_q <= rot_res;
                flags_we_q <= 1'b1;
                flags_q <= rot_flags;
            end
        end
    end

    // nmi return: pc from the stack word, sp advanced, masks restored
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pc_load_q <= 1'b0;
            pc_q <= rlnr_pkg::WORD_RST;
            sp_load_q <= 1'b0;
            sp_q <= rlnr_pkg::WORD_RST;
            msw_load_q <= 1'b0;
            master_status_word_q <= 8'h00;
        end else if (clk_en) begin
            pc_load_q <= 1'b0;
            sp_load_q <= 1'b0;
            msw_load_q <= 1'b0;
            if (state_q == rlnr_pkg::ST_STACK && mem_ack) begin
                pc_load_q <= 1'b1;
                pc_q <= mem_rdata;
                sp_load_q <= 1'b1;
                sp_q <= 16'(mem_addr_q + rlnr_pkg::SP_STEP);
                msw_load_q <= 1'b1;
                master_status_word_q <= saved_interrupt_mask_copy;
            end
        end
    end

    chk_pc_from_stack: assert property (@(posedge clk) disable iff (!reset_n)
        clk_en && state_q == rlnr_pkg::ST_STACK && mem_ack |=>
            pc_load_q && pc_q == $past(mem_rdata))
        else $error("pc not loaded from stack word");
    chk_sp_plus_two: assert property (@(posedge clk) disable iff (!reset_n)
        pc_load_q |-> sp_load_q && sp_q == 16'($past(mem_addr_q) + 16'h0002))
        else $error("stack pointer not advanced by two");
    chk_mask_restore: assert property (@(posedge clk) disable iff (!reset_n)
        $rose(msw_load_q) |-> master_status_word_q == $past(saved_interrupt_mask_copy))
        else $error("interrupt masks not restored");
    chk_rotate_value: assert property (@(posedge clk) disable iff (!reset_n)
        reg_we_q |-> reg_wdata_q == {$past(reg_rd_data[6:0]), $past(flags_in[0])})
        else $error("rotate result wrong");
    chk_zero_hn_flags: assert property (@(posedge clk) disable iff (!reset_n)
        flags_we_q |-> flags_q[6] == (res_q == 8'h00) && !flags_q[4] && !flags_q[1])
        else $error("zero, half or subtract flag wrong");
    chk_parity_flag: assert property (@(posedge clk) disable iff (!reset_n)
        flags_we_q |-> flags_q[2] == ~^res_q)
        else $error("parity flag wrong");
    chk_carry_out: assert property (@(posedge clk) disable iff (!reset_n)
        reg_we_q |-> flags_we_q && flags_q[0] == $past(reg_rd_data[7]))
        else $error("carry not old bit 7");
    chk_reg_decode: assert property (@(posedge clk) disable iff (!reset_n)
        take && state_q == rlnr_pkg::ST_BIT && ins_byte == 8'h12 |=>
            state_q == rlnr_pkg::ST_REG_RD ##1 reg_we_q && reg_sel_q == 3'h2)
        else $error("register form not decoded");
    chk_index_addr: assert property (@(posedge clk) disable iff (!reset_n)
        take && state_q == rlnr_pkg::ST_IDX_OP && ins_byte == 8'h16 |=>
            mem_req_q && !mem_we_q && mem_addr_q == $past(idx_addr))
        else $error("indexed operand address wrong");
    chk_sign_flag: assert property (@(posedge clk) disable iff (!reset_n)
        flags_we_q |-> flags_q[7] == res_q[7])
        else $error("sign flag not result bit 7");
endmodule : rlnr_core

// *** testbench/rlnr_core_tb.sv ***
// self-checking bench for the rotate-through-carry / nmi-return slice
// assumes rlnr_pkg is compiled first; the bench plays register file and memory
`timescale 1ns/1ns
module rotate_left_and_nmi_return_tb_top;
    logic clk = 1'b0; // 100 MHz core clock
    logic reset_n; // async reset, active low
    logic clk_en, ins_valid, mem_ack;
    logic [7:0] ins_byte, flags_in, reg_rd_data, saved_interrupt_mask_copy;
    logic [15:0] stack_ptr_in, pointer_pair, first_index_reg, second_index_reg, mem_rdata;
    logic ins_ready_q, mem_req_q, mem_we_q, mem_word_q, reg_we_q, flags_we_q;
    logic pc_load_q, sp_load_q, msw_load_q;
    logic [15:0] mem_addr_q, pc_q, sp_q;
    logic [7:0] mem_wdata_q, reg_wdata_q, flags_q, master_status_word_q;
    logic [2:0] reg_sel_q;
    int bad_count = 0; // mismatches seen
    int check_count = 0; // comparisons made

    // free-running clock
    always #5 clk = ~clk;

    rlnr_core #(.ADDR_W(16)) uut (.clk(clk), .reset_n(reset_n), .clk_en(clk_en),
        .ins_valid(ins_valid), .ins_byte(ins_byte), .ins_ready_q(ins_ready_q),
        .flags_in(flags_in), .reg_rd_data(reg_rd_data), .stack_ptr_in(stack_ptr_in),
        .pointer_pair(pointer_pair), .first_index_reg(first_index_reg),
        .second_index_reg(second_index_reg),
        .saved_interrupt_mask_copy(saved_interrupt_mask_copy), .mem_ack(mem_ack),
        .mem_rdata(mem_rdata), .mem_req_q(mem_req_q), .mem_we_q(mem_we_q),
        .mem_word_q(mem_word_q), .mem_addr_q(mem_addr_q), .mem_wdata_q(mem_wdata_q),
        .reg_sel_q(reg_sel_q), .reg_we_q(reg_we_q), .reg_wdata_q(reg_wdata_q),
        .flags_we_q(flags_we_q), .flags_q(flags_q), .pc_load_q(pc_load_q), .pc_q(pc_q),
        .sp_load_q(sp_load_q), .sp_q(sp_q), .msw_load_q(msw_load_q),
        .master_status_word_q(master_status_word_q));

    // single exit point: counts, then verdict
    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : end_sim

    // four-state compare, so an unknown never matches
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // expected {result, flags}; bits 3 and 5 ride through untouched
    function automatic logic [15:0] rot_exp(input logic [7:0] op, input logic [7:0] fin);
        logic [7:0] r;
        r = {op[6:0], fin[0]};
        return {r, r[7], (r == 8'h00), fin[5], 1'b0, fin[3], ~^r, 1'b0, op[7]};
    endfunction : rot_exp

    // bounded wait at falling edges: 0 flags, 1 request, 2 pc load, 3 ready
    task automatic wait_sig(input int which);
        int n;
        logic hit;
        n = 0;
        hit = 1'b0;
        while (!hit) begin
            @(negedge clk);
            case (which)
                0: hit = (flags_we_q === 1'b1);
                1: hit = (mem_req_q === 1'b1);
                2: hit = (pc_load_q === 1'b1);
                default: hit = (ins_ready_q === 1'b1);
            endcase
            n++;
            if (!hit && n > 40) begin
                bad_count++;
                $display("ERROR at %0t: wait %h got %h expected %h", $time, which, 1'b0, 1'b1);
                end_sim();
            end
        end
    endtask : wait_sig

    // offer one byte; valid stays up so bytes can go back to back
    task automatic send(input logic [7:0] b);
        ins_byte <= b;
        ins_valid <= 1'b1;
        wait_sig(3);
        @(posedge clk);
    endtask : send

    // one-cycle acknowledge; data released to its inverse afterwards
    task automatic mem_answer(input logic [15:0] d);
        @(posedge clk);
        mem_ack <= 1'b1;
        mem_rdata <= d;
        @(posedge clk);
        mem_ack <= 1'b0;
        mem_rdata <= ~d;
    endtask : mem_answer

    // register operand for every field except memory, mixed carry-in and flags
    task automatic reg_forms();
        logic [7:0] ops [8] = '{8'h88, 8'h80, 8'h7F, 8'h00, 8'h55, 8'hC3, 8'h00, 8'h01};
        logic [7:0] fin;
        logic [15:0] exp;
        for (int r = 0; r < 8; r++) begin
            if (r != 6) begin
                fin = (r[1] ? 8'hFE : 8'hD6) | {7'h00, r[0]};
                flags_in <= fin;
                reg_rd_data <= ops[r];
                exp = rot_exp(ops[r], fin);
                send(rlnr_pkg::BIT_PFX);
                send({rlnr_pkg::ROT_GRP, 3'(r)});
                ins_valid <= 1'b0;
                wait_sig(0);
                chk(16'(reg_we_q), 16'h0001);
                chk(16'(reg_sel_q), 16'(r));
                chk(16'(reg_wdata_q), 16'(exp[15:8]));
                chk(16'(flags_q), 16'(exp[7:0]));
                @(negedge clk);
                chk(16'({flags_we_q, reg_we_q}), 16'h0000);
                @(posedge clk);
            end
        end
    endtask : reg_forms

    // memory operand: plain pointer form when pfx is zero, else indexed form
    task automatic mem_rot(input logic [7:0] pfx, input logic [7:0] disp,
                           input logic [15:0] addr, input logic [7:0] op);
        logic [15:0] exp;
        if (pfx != 8'h00) begin
            send(pfx);
            send(rlnr_pkg::BIT_PFX);
            send(disp);
        end else begin
            send(rlnr_pkg::BIT_PFX);
        end
        send({rlnr_pkg::ROT_GRP, rlnr_pkg::MEM_FIELD});
        // flags_in is settled by now; a caller's late update has landed
        exp = rot_exp(op, flags_in);
        ins_valid <= 1'b0;
        wait_sig(1);
        chk(mem_addr_q, addr);
        chk(16'({mem_we_q, mem_word_q}), 16'h0000);
        mem_answer({8'hA5, op});
        wait_sig(0);
        chk(16'(flags_q), 16'(exp[7:0]));
        chk(16'(mem_wdata_q), 16'(exp[15:8]));
        wait_sig(1);
        chk(16'(mem_we_q), 16'h0001);
        chk(mem_addr_q, addr);
        mem_answer(16'h0000);
        wait_sig(3);
        chk(16'(mem_req_q), 16'h0000);
        @(posedge clk);
    endtask : mem_rot

    // clock enable low freezes the sequencer between decode and write-back
    task automatic stall_rot();
        flags_in <= 8'h00;
        reg_rd_data <= 8'hB4;
        send(rlnr_pkg::BIT_PFX);
        send({rlnr_pkg::ROT_GRP, 3'h5});
        ins_valid <= 1'b0;
        clk_en <= 1'b0;
        repeat (3) @(negedge clk);
        chk(16'({reg_we_q, flags_we_q, ins_ready_q}), 16'h0000);
        @(posedge clk);
        clk_en <= 1'b1;
        wait_sig(0);
        chk({reg_wdata_q, flags_q}, rot_exp(8'hB4, 8'h00));
        @(posedge clk);
    endtask : stall_rot

    // pop pc from stack, step the pointer, restore the mask copy
    task automatic nmi_ret(input logic [15:0] sp, input logic [15:0] word, input logic [7:0] m);
        stack_ptr_in <= sp;
        saved_interrupt_mask_copy <= m;
        send(rlnr_pkg::EXT_PFX);
        send(rlnr_pkg::NMI_RET_OP);
        ins_valid <= 1'b0;
        wait_sig(1);
        chk(16'({mem_word_q, mem_we_q}), 16'h0002);
        chk(mem_addr_q, sp);
        mem_answer(word);
        wait_sig(2);
        chk(pc_q, word);
        chk(sp_q, sp + rlnr_pkg::SP_STEP);
        chk(16'({sp_load_q, msw_load_q}), 16'h0003);
        chk(16'(master_status_word_q), 16'(m));
        wait_sig(3);
        @(posedge clk);
    endtask : nmi_ret

    // main sequence
    initial begin
        reset_n = 1'b0;
        clk_en = 1'b1;
        ins_valid = 1'b0;
        ins_byte = 8'h00;
        flags_in = 8'h00;
        reg_rd_data = 8'h00;
        stack_ptr_in = 16'h0000;
        pointer_pair = 16'h4321;
        first_index_reg = 16'h1000;
        second_index_reg = 16'h2000;
        saved_interrupt_mask_copy = 8'h00;
        mem_ack = 1'b0;
        mem_rdata = 16'h0000;
        repeat (10) @(posedge clk);
        chk(16'({mem_req_q, reg_we_q, flags_we_q, pc_load_q, ins_ready_q}), 16'h0000);
        reset_n <= 1'b1;
        @(posedge clk);
        reg_forms();
        stall_rot();
        // a stray byte must leave the decoder idle
        send(8'h00);
        flags_in <= 8'hD7;
        mem_rot(8'h00, 8'h00, 16'h4321, 8'h81);
        mem_rot(rlnr_pkg::IDX_PFX_A, 8'hF0, 16'h0FF0, 8'h00);
        mem_rot(rlnr_pkg::IDX_PFX_B, 8'h05, 16'h2005, 8'hFF);
        nmi_ret(16'hFFC6, 16'h1972, 8'h7F);
        nmi_ret(16'hFFFE, 16'hABCD, 8'h3C);
        // word-size flag left by the return must not leak into a byte access
        mem_rot(8'h00, 8'h00, 16'h4321, 8'h40);
        end_sim();
    end
endmodule : rotate_left_and_nmi_return_tb_top
